// file: core/ldw_pkg.sv
// Shared constants, types and decode tables for the LED display write port.
// Assumes a single 125 MHz clock; all pins are synchronised by the top module.
package ldw_pkg;

   // ----------------------------------------------------------------------
   // Clock and scan timing
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ           = 125;
   localparam int SCAN_DIGIT_NS     = 2000;
   localparam int SCAN_DIGIT_CYCLES = (SCAN_DIGIT_NS * CLK_MHZ) / 1000;
   localparam int GAP_NS            = 80;
   localparam int GAP_CYCLES        = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] SCAN_LAST = 8'(SCAN_DIGIT_CYCLES - 1);
   localparam logic [7:0] GAP_END   = 8'(GAP_CYCLES);
   localparam logic [2:0] DIGIT_LAST = 3'h7;

   // ----------------------------------------------------------------------
   // Control word, bit order equals data lines 7 down to 0
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       seq_follow;  // Line 7: eight writes follow
      logic       hex_sel;     // Line 6: high hex, low alternate code
      logic       raw_mode;    // Line 5: high raw segments
      logic       run;         // Line 4: low means shutdown
      logic       bank_a;      // Line 3: high bank A, low bank B
      logic [2:0] digit_addr;  // Lines 2..0, line 2 is the MSB
   } ldw_ctl_t;

   localparam ldw_ctl_t CTL_RESET = 8'h58;

   // ----------------------------------------------------------------------
   // Display RAM word: shared point bit plus one nibble per bank
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       point_n;
      logic [3:0] nib_b;
      logic [3:0] nib_a;
   } ldw_word_t;

   localparam logic [8:0] WORD_RESET  = 9'h100;
   localparam logic [8:0] MASK_RAW    = 9'h17F;
   localparam logic [8:0] MASK_BANK_A = 9'h10F;
   localparam logic [8:0] MASK_BANK_B = 9'h1F0;

   // ----------------------------------------------------------------------
   // Write sequencer states and three-level input codes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      LDW_ST_LOCKED = 2'b00,
      LDW_ST_SEQ    = 2'b01,
      LDW_ST_SINGLE = 2'b10
   } ldw_wr_state_t;

   localparam logic [1:0] FUNC_HIGH  = 2'h3;
   localparam logic [1:0] FUNC_FLOAT = 2'h1;
   localparam logic [1:0] FUNC_LOW   = 2'h0;

   // ----------------------------------------------------------------------
   // Character tables, segments ordered g f e d c b a
   // ----------------------------------------------------------------------
   function automatic logic [6:0] ldw_decode(input logic hex, input logic [3:0] code);
      logic [6:0] seg;
      seg = 7'h00;
      case (code)
         4'h0: seg = 7'h3F;
         4'h1: seg = 7'h06;
         4'h2: seg = 7'h5B;
         4'h3: seg = 7'h4F;
         4'h4: seg = 7'h66;
         4'h5: seg = 7'h6D;
         4'h6: seg = 7'h7D;
         4'h7: seg = 7'h07;
         4'h8: seg = 7'h7F;
         4'h9: seg = 7'h6F;
         4'hA: seg = hex ? 7'h77 : 7'h40;
         4'hB: seg = hex ? 7'h7C : 7'h79;
         4'hC: seg = hex ? 7'h39 : 7'h76;
         4'hD: seg = hex ? 7'h5E : 7'h38;
         4'hE: seg = hex ? 7'h79 : 7'h73;
         default: seg = hex ? 7'h71 : 7'h00;
      endcase
      return seg;
   endfunction

endpackage

// file: core/ldw_ram8.sv
// Eight-word display RAM with a bit-masked write port and registered read.
// Assumes write and read come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ldw_ram8
   import ldw_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       wr_en_in,
   input  wire logic [2:0] wr_addr_in,
   input  wire logic [8:0] wr_mask_in,
   input  wire logic [8:0] wr_data_in,
   input  wire logic [2:0] rd_addr_in,
   output logic      [8:0] rd_data_out
);

   // ----------------------------------------------------------------------
   // Storage, one entry per digit
   // ----------------------------------------------------------------------
   logic [8:0] mem_reg [8];

   // Masked write keeps the untouched bank intact; every mask used also rewrites the shared point
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_word
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               mem_reg[gi] <= WORD_RESET;
            end else if (ce_in && wr_en_in && (wr_addr_in == 3'(gi))) begin
               mem_reg[gi] <= (mem_reg[gi] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
            end
         end
      end
   endgenerate

   // Registered read port
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= WORD_RESET;
      end else if (ce_in) begin
         rd_data_out <= mem_reg[rd_addr_in];
      end
   end

endmodule
`default_nettype wire

// file: core/ldw_write_port.sv
// Write port, display RAM and scan of an eight-digit seven-segment driver.
// Assumes the host pins are asynchronous; strobe edges must be far slower
// than the clock (pulses of several cycles, with setup before the rise).
//
// Overview of operation
// - Two write-only locations, control latch or display RAM, picked by select.
// - Data are captured on the strobe's rising edge.
// - Select high loads the control latch, low loads the display RAM.
// - Line 6 hex/alternate code, line 5 raw segments, line 4 low shutdown.
// - Line 3 selects bank A or B in decode modes; lines 2..0 digit address.
// - Each entry sequence starts with a control word, configuring all modes.
// - RAM holds banks A and B, selectable in decoded formats.
// - Bank selection ignored in raw mode, which uses all eight bits.
// - Decimal point storage is shared by both banks.
// - Latched bank bit steers data writes and the displayed bank.
// - Control word without sequence bit changes only control, keeps data.
// - Sequence bit high blanks display and starts a sequential update.
// - Eight sequential writes land in digit 1 through digit 8, chosen bank.
// - After the eighth write blanking ends and new data show.
// - After a sequential update further data writes are ignored.
// - Digits show the format set by the preceding control word.
// - Direct variant writes RAM on strobe rise, no control latch.
// - Direct variant point input is active low, low lights the point.
// - Three-level input: high hex, float alternate code, low shutdown.
// - Eight digit drives, seven segment drives and one point drive.
`timescale 1ns/1ps
`default_nettype none
module ldw_write_port
   import ldw_pkg::*;
(
   input  wire logic       CLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic       CE_IN,
   input  wire logic       VARIANT_DIRECT_IN,
   input  wire logic       WRITE_N_IN,
   input  wire logic       SELECT_IN,
   input  wire logic [7:0] DATA_LINE_IN,
   input  wire logic [2:0] DIGIT_SEL_IN,
   input  wire logic       POINT_DATA_IN_N,
   input  wire logic [1:0] TRI_LEVEL_FUNCTION_IN,
   output logic      [7:0] DIGIT_DRIVE_OUT,
   output logic      [6:0] SEGMENT_DRIVE_OUT,
   output logic            POINT_DRIVE_OUT,
   output logic            BLANKED_OUT,
   output logic            SHUTDOWN_OUT,
   output logic            SEQ_BUSY_OUT
);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_n;

   // Asserts at once, releases two edges later
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [15:0] pin_s1_reg;
   logic [15:0] pin_s2_reg;
   logic [15:0] pin_d3_reg;
   logic [15:0] pin_raw;

   assign pin_raw = {TRI_LEVEL_FUNCTION_IN, VARIANT_DIRECT_IN, POINT_DATA_IN_N,
                     DIGIT_SEL_IN, SELECT_IN, DATA_LINE_IN};

   // Third stage gives the value seen while the strobe was still low, so
   // a zero-hold change at the rising edge cannot corrupt the capture
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= 16'h0000;
         pin_s2_reg <= 16'h0000;
         pin_d3_reg <= 16'h0000;
      end else if (CE_IN) begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_d3_reg <= pin_s2_reg;
      end
   end

   logic strobe_s1_reg;
   logic strobe_s2_reg;
   logic strobe_d3_reg;

   // Strobe idles high
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         strobe_s1_reg <= 1'b1;
         strobe_s2_reg <= 1'b1;
         strobe_d3_reg <= 1'b1;
      end else if (CE_IN) begin
         strobe_s1_reg <= WRITE_N_IN;
         strobe_s2_reg <= strobe_s1_reg;
         strobe_d3_reg <= strobe_s2_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Captured write fields
   // ----------------------------------------------------------------------
   logic       wr_rise;
   logic [7:0] wr_data;
   logic       wr_select;
   logic [2:0] wr_digit;
   logic       wr_point_n;
   logic       direct;
   logic [1:0] func_level;

   assign wr_rise    = strobe_s2_reg & ~strobe_d3_reg;
   assign wr_data    = pin_d3_reg[7:0];
   assign wr_select  = pin_d3_reg[8];
   assign wr_digit   = pin_d3_reg[11:9];
   assign wr_point_n = pin_d3_reg[12];
   assign direct     = pin_s2_reg[13];
   assign func_level = pin_s2_reg[15:14];

   // ----------------------------------------------------------------------
   // Control latch and write sequencer
   // ----------------------------------------------------------------------
   ldw_ctl_t      ctl_reg;
   ldw_wr_state_t state_reg;
   logic [2:0]    seq_idx_reg;
   logic          blank_reg;
   logic          ctl_wr;
   logic          ram_wr;

   assign ctl_wr = wr_rise & ~direct & wr_select;
   assign ram_wr = wr_rise & ~direct & ~wr_select;

   // Control word taken whole; its bits steer every later action outside the direct variant
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= CTL_RESET;
      end else if (CE_IN && ctl_wr) begin
         ctl_reg <= ldw_ctl_t'(wr_data);
      end
   end

   // Sequencer: a new control word always restarts it
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= LDW_ST_LOCKED;
         seq_idx_reg <= 3'h0;
      end else if (CE_IN) begin
         if (ctl_wr) begin
            seq_idx_reg <= 3'h0;
            if (wr_data[7]) begin
               state_reg <= LDW_ST_SEQ;
            end else begin
               state_reg <= LDW_ST_SINGLE;
            end
         end else if (ram_wr) begin
            case (state_reg)
               LDW_ST_SEQ: begin
                  seq_idx_reg <= seq_idx_reg + 3'h1;
                  if (seq_idx_reg == DIGIT_LAST) begin
                     state_reg <= LDW_ST_LOCKED;
                  end
               end
               LDW_ST_SINGLE: begin
                  state_reg <= LDW_ST_LOCKED;
               end
               default: begin
                  state_reg <= LDW_ST_LOCKED;
               end
            endcase
         end
      end
   end

   // Blanking spans the whole sequential load
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         blank_reg <= 1'b0;
      end else if (CE_IN) begin
         if (ctl_wr) begin
            blank_reg <= wr_data[7];
         end else if (ram_wr && state_reg == LDW_ST_SEQ && seq_idx_reg == DIGIT_LAST) begin
            blank_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // RAM write path
   // ----------------------------------------------------------------------
   logic       mem_we;
   logic [2:0] mem_addr;
   logic [8:0] mem_mask;
   logic [8:0] mem_data;

   // Point bit is written with every word into shared storage
   always_comb begin
      mem_we   = 1'b0;
      mem_addr = ctl_reg.digit_addr;
      mem_mask = MASK_BANK_A;
      mem_data = {wr_data[7], 4'h0, wr_data[3:0]};
      if (direct) begin
         mem_we   = wr_rise;
         mem_addr = wr_digit;
         mem_data = {wr_point_n, 4'h0, wr_data[3:0]};
      end else begin
         mem_we = ram_wr && (state_reg != LDW_ST_LOCKED);
         if (state_reg == LDW_ST_SEQ) begin
            mem_addr = seq_idx_reg;
         end
         if (ctl_reg.raw_mode) begin
            mem_mask = MASK_RAW;
            mem_data = {wr_data[7], 1'b0, wr_data[6:0]};
         end else if (!ctl_reg.bank_a) begin
            mem_mask = MASK_BANK_B;
            mem_data = {wr_data[7], wr_data[3:0], 4'h0};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Display RAM
   // ----------------------------------------------------------------------
   logic [2:0] scan_idx_reg;
   ldw_word_t  rd_word;

   ldw_ram8 u_ram (
      .clk_in      (CLK_IN),
      .rst_n_in    (rst_n),
      .ce_in       (CE_IN),
      .wr_en_in    (mem_we),
      .wr_addr_in  (mem_addr),
      .wr_mask_in  (mem_mask),
      .wr_data_in  (mem_data),
      .rd_addr_in  (scan_idx_reg),
      .rd_data_out (rd_word)
   );

   // ----------------------------------------------------------------------
   // Effective display format
   // ----------------------------------------------------------------------
   logic eff_hex;
   logic eff_raw;
   logic eff_bank_a;
   logic eff_shut;

   // Direct variant takes its format from the three-level pin
   always_comb begin
      if (direct) begin
         eff_hex    = (func_level == FUNC_HIGH);
         eff_shut   = (func_level == FUNC_LOW);
         eff_raw    = 1'b0;
         eff_bank_a = 1'b1;
      end else begin
         eff_hex    = ctl_reg.hex_sel;
         eff_raw    = ctl_reg.raw_mode;
         eff_bank_a = ctl_reg.bank_a | ctl_reg.raw_mode;
         eff_shut   = ~ctl_reg.run;
      end
   end

   // ----------------------------------------------------------------------
   // Digit scan
   // ----------------------------------------------------------------------
   logic [7:0] presc_reg;

   // Scan freezes in shutdown; data entry still works meanwhile
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         presc_reg    <= 8'h00;
         scan_idx_reg <= 3'h0;
      end else if (CE_IN && !eff_shut) begin
         if (presc_reg == SCAN_LAST) begin
            presc_reg    <= 8'h00;
            scan_idx_reg <= scan_idx_reg + 3'h1;
         end else begin
            presc_reg <= presc_reg + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Segment pattern
   // ----------------------------------------------------------------------
   logic [3:0] code;
   logic [6:0] pattern;

   // Raw bit order: 6 a, 5 b, 4 c, 3 e, 2 g, 1 f, 0 d
   always_comb begin
      code    = eff_bank_a ? rd_word.nib_a : rd_word.nib_b;
      pattern = ldw_decode(eff_hex, code);
      if (eff_raw) begin
         pattern = {rd_word.nib_b[2], rd_word.nib_a[1], rd_word.nib_a[3],
                    rd_word.nib_a[0], rd_word.nib_b[0], rd_word.nib_b[1],
                    rd_word.nib_b[2]};
         pattern[0] = rd_word.nib_b[2];
         pattern[6] = rd_word.nib_a[2];
      end
   end

   // ----------------------------------------------------------------------
   // Output drivers
   // ----------------------------------------------------------------------
   logic lit;

   // Guard band at each digit change keeps two digits from overlapping
   assign lit = ~eff_shut & ~blank_reg & (presc_reg >= GAP_END);

   // Digit drives, one hot while lit
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         DIGIT_DRIVE_OUT <= 8'h00;
      end else if (CE_IN) begin
         DIGIT_DRIVE_OUT <= lit ? (8'h01 << scan_idx_reg) : 8'h00;
      end
   end

   // Segment and point drives follow the RAM word two cycles behind
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         SEGMENT_DRIVE_OUT <= 7'h00;
         POINT_DRIVE_OUT   <= 1'b0;
      end else if (CE_IN) begin
         SEGMENT_DRIVE_OUT <= (eff_shut | blank_reg) ? 7'h00 : pattern;
         POINT_DRIVE_OUT   <= ~(eff_shut | blank_reg | rd_word.point_n);
      end
   end

   // Status outputs
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         BLANKED_OUT  <= 1'b0;
         SHUTDOWN_OUT <= 1'b0;
         SEQ_BUSY_OUT <= 1'b0;
      end else if (CE_IN) begin
         BLANKED_OUT  <= blank_reg;
         SHUTDOWN_OUT <= eff_shut;
         SEQ_BUSY_OUT <= (state_reg == LDW_ST_SEQ);
      end
   end

endmodule
`default_nettype wire

// file: sim/ldw_host_model.sv
// Behavioural bus master that writes to the LED display write port.
// Assumes the caller is a testbench calling wr from one thread at a time.
`timescale 1ns/1ps
`default_nettype none
module ldw_host_model (
   input  wire logic       clk_in,
   output logic            write_n_out,
   output logic            select_out,
   output logic      [7:0] data_out,
   output logic      [2:0] digit_sel_out,
   output logic            point_n_out
);
   // ------------
   // Idle bus
   // ------------
   initial begin
      write_n_out = 1'b1;
      select_out = 1'b0;
      data_out = 8'h00;
      digit_sel_out = 3'h0;
      point_n_out = 1'b1;
   end

   // One write cycle; select has its own line, the strobe is only the timing pulse
   task automatic wr(input logic sel, input logic [2:0] addr, input logic [7:0] d, input logic pn);
      @(negedge clk_in);
      select_out = sel;
      data_out = d;
      digit_sel_out = addr;
      point_n_out = pn;
      write_n_out = 1'b0;
      repeat (4) @(negedge clk_in);
      write_n_out = 1'b1;
      repeat (2) @(negedge clk_in);
      // Released bus shows the inverse, so stale data never look valid
      select_out = ~sel;
      data_out = ~d;
      digit_sel_out = ~addr;
      point_n_out = ~pn;
      repeat (6) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// file: sim/ldw_write_port_checker.sv
// Port-level assertions for the LED display write port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ldw_write_port_checker (
   input  wire logic       CLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic       VARIANT_DIRECT_IN,
   input  wire logic       WRITE_N_IN,
   input  wire logic       SELECT_IN,
   input  wire logic [7:0] DATA_LINE_IN,
   input  wire logic [1:0] TRI_LEVEL_FUNCTION_IN,
   input  wire logic [7:0] DIGIT_DRIVE_OUT,
   input  wire logic       BLANKED_OUT,
   input  wire logic       SHUTDOWN_OUT,
   input  wire logic       SEQ_BUSY_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   // ------------
   // Scan and drives
   // ------------
   property p_drive_onehot;
      $onehot0(DIGIT_DRIVE_OUT);
   endproperty
   a_drive_onehot: assert property (p_drive_onehot) else $error("two digits driven at once");
   property p_drive_steady;
      (DIGIT_DRIVE_OUT != 8'h00 && $past(DIGIT_DRIVE_OUT) != 8'h00) |-> DIGIT_DRIVE_OUT == $past(DIGIT_DRIVE_OUT);
   endproperty
   a_drive_steady: assert property (p_drive_steady) else $error("digit changed without a gap");
   property p_shut_dark;
      SHUTDOWN_OUT [*3] |-> DIGIT_DRIVE_OUT == 8'h00;
   endproperty
   a_shut_dark: assert property (p_shut_dark) else $error("digit driven in shutdown");
   property p_blank_dark;
      BLANKED_OUT [*3] |-> DIGIT_DRIVE_OUT == 8'h00;
   endproperty
   a_blank_dark: assert property (p_blank_dark) else $error("digit driven while blanked");

   // ------------
   // Control word and three-level input effects
   // ------------
   property p_seq_start;
      ($rose(WRITE_N_IN) && SELECT_IN && DATA_LINE_IN[7] && !VARIANT_DIRECT_IN) |-> ##7 (BLANKED_OUT && SEQ_BUSY_OUT);
   endproperty
   a_seq_start: assert property (p_seq_start) else $error("sequence word did not blank");
   property p_ctl_run;
      ($rose(WRITE_N_IN) && SELECT_IN && !VARIANT_DIRECT_IN) |-> ##7 (SHUTDOWN_OUT != $past(DATA_LINE_IN[4], 7));
   endproperty
   a_ctl_run: assert property (p_ctl_run) else $error("shutdown does not follow line 4");
   property p_busy_blank;
      SEQ_BUSY_OUT |-> BLANKED_OUT;
   endproperty
   a_busy_blank: assert property (p_busy_blank) else $error("loading without blanking");
   property p_done_lit;
      $fell(SEQ_BUSY_OUT) |-> $fell(BLANKED_OUT);
   endproperty
   a_done_lit: assert property (p_done_lit) else $error("blanking outlived the load");
   property p_direct_shut;
      (VARIANT_DIRECT_IN && $stable(TRI_LEVEL_FUNCTION_IN)) [*8] |-> SHUTDOWN_OUT == (TRI_LEVEL_FUNCTION_IN == 2'h0);
   endproperty
   a_direct_shut: assert property (p_direct_shut) else $error("three-level shutdown wrong");

   c_seq_done: cover property ($fell(SEQ_BUSY_OUT));
   c_blank: cover property ($rose(BLANKED_OUT));
   c_shut: cover property ($rose(SHUTDOWN_OUT));
endmodule
`default_nettype wire

// file: sim/ldw_write_port_tb_top.sv
// Self-checking bench for the LED display write port.
// Assumes ldw_pkg, the design and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ldw_write_port_tb_top;
   logic       clk;
   logic       rst_n;
   logic       variant;
   logic       write_n;
   logic       sel;
   logic       point_n;
   logic [7:0] data;
   logic [2:0] dsel;
   logic [1:0] tri_fn;
   logic [7:0] digit;
   logic [6:0] seg;
   logic       pt;
   logic       blanked;
   logic       shut;
   logic       busy;
   int         failures;
   int         checks_done;
   // Patterns for codes 8..F, segments g..a
   logic [6:0] hex_hi [8] = '{7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
   logic [6:0] alt_hi [8] = '{7'h7F, 7'h6F, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   ldw_host_model i_ldw_host_model (.clk_in(clk), .write_n_out(write_n), .select_out(sel), .data_out(data),
      .digit_sel_out(dsel), .point_n_out(point_n));
   ldw_write_port i_ldw_write_port (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .VARIANT_DIRECT_IN(variant),
      .WRITE_N_IN(write_n), .SELECT_IN(sel), .DATA_LINE_IN(data), .DIGIT_SEL_IN(dsel), .POINT_DATA_IN_N(point_n),
      .TRI_LEVEL_FUNCTION_IN(tri_fn), .DIGIT_DRIVE_OUT(digit), .SEGMENT_DRIVE_OUT(seg), .POINT_DRIVE_OUT(pt),
      .BLANKED_OUT(blanked), .SHUTDOWN_OUT(shut), .SEQ_BUSY_OUT(busy));

   // ------------
   // Helpers
   // ------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waits for a fresh slot of digit d, so stale segments are never sampled
   task automatic see(input int d, input logic [6:0] s, input logic p);
      int n;
      n = 0;
      while (digit !== 8'h00 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      while (digit !== (8'h01 << d) && n < 6000) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      chk("digit", 8'h01 << d, digit);
      chk("segments", {1'b0, s}, {1'b0, seg});
      chk("point", {7'h00, p}, {7'h00, pt});
   endtask

   function automatic logic [7:0] rawd(input int i);
      return (i == 7) ? 8'h00 : {1'b1, 7'h01 << i};
   endfunction

   // Raw byte to segments g f e d c b a
   function automatic logic [6:0] remap(input logic [7:0] d);
      return {d[2], d[1], d[3], d[0], d[4], d[5], d[6]};
   endfunction

   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ------------
   // Tests
   // ------------
   initial begin
      failures = 0;
      checks_done = 0;
      rst_n = 1'b0;
      variant = 1'b0;
      tri_fn = ldw_pkg::FUNC_HIGH;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      see(0, 7'h3F, 1'b0);
      // Sequential load into bank A, hex, point on digit 3
      i_ldw_host_model.wr(1'b1, 3'h0, 8'hD8, 1'b1);
      chk("blanked", 8'h01, {7'h00, blanked});
      for (int i = 0; i < 8; i++) i_ldw_host_model.wr(1'b0, 3'h0, {i != 2, 3'h0, 4'(8 + i)}, 1'b1);
      chk("busy", 8'h00, {7'h00, busy});
      chk("blanked", 8'h00, {7'h00, blanked});
      for (int i = 0; i < 8; i++) see(i, hex_hi[i], i == 2);
      i_ldw_host_model.wr(1'b0, 3'h0, 8'h81, 1'b1);
      see(0, 7'h7F, 1'b0);
      // Control only: bank B, alternate code, shared point stays
      i_ldw_host_model.wr(1'b1, 3'h0, 8'h10, 1'b1);
      chk("blanked", 8'h00, {7'h00, blanked});
      see(2, 7'h3F, 1'b1);
      // Second bank loaded while the first must survive
      i_ldw_host_model.wr(1'b1, 3'h0, 8'h90, 1'b1);
      for (int i = 0; i < 8; i++) i_ldw_host_model.wr(1'b0, 3'h0, {4'h8, 4'(8 + i)}, 1'b1);
      for (int i = 0; i < 8; i++) see(i, alt_hi[i], 1'b0);
      i_ldw_host_model.wr(1'b1, 3'h0, 8'h58, 1'b1);
      see(2, hex_hi[2], 1'b0);
      see(5, hex_hi[5], 1'b0);
      // Single word steered by the latched digit address, point on
      i_ldw_host_model.wr(1'b1, 3'h0, 8'h5D, 1'b1);
      i_ldw_host_model.wr(1'b0, 3'h0, 8'h03, 1'b1);
      see(5, 7'h4F, 1'b1);
      // Raw segments with bank B requested, which must not matter
      i_ldw_host_model.wr(1'b1, 3'h0, 8'hB0, 1'b1);
      for (int i = 0; i < 8; i++) i_ldw_host_model.wr(1'b0, 3'h0, rawd(i), 1'b1);
      for (int i = 0; i < 8; i++) see(i, remap(rawd(i)), rawd(i) < 8'h80);
      // Shutdown and wake through the control word
      i_ldw_host_model.wr(1'b1, 3'h0, 8'h48, 1'b1);
      chk("shutdown", 8'h01, {7'h00, shut});
      repeat (300) @(negedge clk);
      chk("drive", 8'h00, digit);
      i_ldw_host_model.wr(1'b1, 3'h0, 8'h58, 1'b1);
      chk("shutdown", 8'h00, {7'h00, shut});
      // Direct-addressed variant
      variant = 1'b1;
      repeat (8) @(negedge clk);
      i_ldw_host_model.wr(1'b0, 3'h3, 8'h05, 1'b0);
      see(3, 7'h6D, 1'b1);
      tri_fn = ldw_pkg::FUNC_FLOAT;
      i_ldw_host_model.wr(1'b0, 3'h6, 8'h0C, 1'b1);
      see(6, 7'h76, 1'b0);
      tri_fn = ldw_pkg::FUNC_LOW;
      repeat (12) @(negedge clk);
      chk("shutdown", 8'h01, {7'h00, shut});
      final_report;
   end

   // Cuts a hang short; the tests need well under this
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      final_report;
   end
endmodule

bind ldw_write_port ldw_write_port_checker i_ldw_write_port_checker (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .VARIANT_DIRECT_IN(VARIANT_DIRECT_IN), .WRITE_N_IN(WRITE_N_IN), .SELECT_IN(SELECT_IN), .DATA_LINE_IN(DATA_LINE_IN),
   .TRI_LEVEL_FUNCTION_IN(TRI_LEVEL_FUNCTION_IN), .DIGIT_DRIVE_OUT(DIGIT_DRIVE_OUT), .BLANKED_OUT(BLANKED_OUT),
   .SHUTDOWN_OUT(SHUTDOWN_OUT), .SEQ_BUSY_OUT(SEQ_BUSY_OUT));
`default_nettype wire
